// [omc_pkg.sv]
// Package for the operating mode controller: register map, field layout,
// reset values, mode encodings and wake stabilisation counts.
// Assumes an AXI4-Lite slave with 32-bit data and byte addresses.
package omc_pkg;
	// --------------------------------------------------------------
	// Register byte offsets
	// --------------------------------------------------------------
	localparam logic [7:0] OMC_OSC_CTRL_OFF = 8'h00;
	localparam logic [7:0] OMC_CFG_OFF = 8'h04;
	localparam logic [7:0] OMC_CTRL_OFF = 8'h08;
	localparam logic [7:0] OMC_STAT_OFF = 8'h0c;
	// --------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------
	localparam int OMC_SEL_HIGH_BIT = 0;
	localparam int OMC_HOSC_STOP_BIT = 1;
	localparam int OMC_MODE_LO_BIT = 2;
	localparam int OMC_PD_BIT = 3;
	localparam int OMC_TO_BIT = 4;
	// --------------------------------------------------------------
	// Operating mode field encodings
	// --------------------------------------------------------------
	localparam logic [1:0] OMC_OP_MODE_FIELD_RUN = 2'h0;
	localparam logic [1:0] OMC_OP_MODE_FIELD_HALT = 2'h1;
	localparam logic [1:0] OMC_OP_MODE_FIELD_STANDBY = 2'h2;
	// --------------------------------------------------------------
	// Reset values and counts
	// --------------------------------------------------------------
	localparam logic [3:0] OMC_OSC_CTRL_RST = 4'h1;
	localparam logic [9:0] OMC_WAKE_XTAL_CYC = 10'h200;
	localparam logic [9:0] OMC_WAKE_RC_CYC = 10'h010;
	typedef enum logic [2:0] {
		OMC_ST_BOOT, OMC_ST_NORMAL, OMC_ST_SLOW, OMC_ST_STANDBY,
		OMC_ST_HALT, OMC_ST_WAKE_WAIT
	} omc_state_t;
endpackage : omc_pkg

// [omc_wake_timer.sv]
// Wake stabilisation counter: loads a cycle count and signals when done.
// Assumes the caller counts one system oscillator cycle per aclk.
`timescale 1ns/1ps
`default_nettype none
module omc_wake_timer #(
	parameter int WIDTH = 10
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;
	logic busy_q;
	logic busy_d;
	logic done_q;
	logic done_d;

	// Next-count selection
	assign cnt_d = load ? count : (busy_q ? cnt_q - 1'b1 : cnt_q);
	assign busy_d = load ? 1'b1 : (busy_q && cnt_q != WIDTH'(1));
	assign done_d = !load && busy_q && cnt_q == WIDTH'(1);

	// Count register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign busy = busy_q;
	assign done = done_q;
endmodule : omc_wake_timer
`default_nettype wire

// [omc_top.sv]
// Operating mode controller: clock select, oscillator stop, standby/halt,
// wake collection, stabilisation delay, execution and peripheral gating.
// Assumes wake and sleep inputs are synchronous to aclk; AXI4-Lite slave.
// Functional notes
// - Startup clock option picks Normal or Slow; here it resets to 1 and is read only at boot, so boot enters Normal
// - Clearing high select enters Slow mode
// - Setting high select returns Normal mode
// - High oscillator stops on stop bit or in Halt
// - Mode field 10b Standby, 01b Halt
// - Sleep enters Halt; PD cleared, TO set, watchdog cleared
// - Halt stops execution, peripherals, both oscillators
// - Standby keeps low oscillator, enabled timers
// - Standby wakes on timer, watchdog, port, edge, LVD, comparator
// - Halt wakes on watchdog, port, edges
// - Wake resumes mode chosen by select bit
// - Halt wake waits 512 or 16 cycles
// - Standby wake resumes with no delay
// - Wake vectors to 0x008 if interrupts enabled
// - Timer0 from low oscillator in Normal
// - Running modes gate peripherals by own enable
// - Instruction clock is oscillator over 2 or 4
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module omc_top #(
	parameter int NUM_TIMERS = 6,
	parameter int NUM_PERIPH = 4,
	parameter logic [10:0] IRQ_VECTOR = 11'h008
) (
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core side
	input wire logic sleep_exec,
	input wire logic irq_global_enable,
	input wire logic [NUM_TIMERS-1:0] timer_run_enable,
	input wire logic [NUM_PERIPH-1:0] periph_enable,
	input wire logic watchdog_option,
	input wire logic watchdog_run_enable,
	input wire logic timer_expire,
	input wire logic watchdog_timeout,
	input wire logic port_change,
	input wire logic ext_irq_zero,
	input wire logic ext_irq_one,
	input wire logic lvd_irq,
	input wire logic cmp_irq,
	output logic cpu_run,
	output logic sys_clk_is_high,
	output logic high_osc_enable,
	output logic low_osc_enable,
	output logic [NUM_TIMERS-1:0] timer_clk_enable,
	output logic timer0_from_low_osc,
	output logic [NUM_PERIPH-1:0] periph_clk_enable,
	output logic watchdog_run,
	output logic watchdog_clear,
	output logic inst_clk_div4,
	output logic wake_vector_take,
	output logic [10:0] wake_vector_addr
);
	omc_pkg::omc_state_t state_q, state_d;
	logic sel_high_q;
	logic hosc_stop_q;
	logic [1:0] op_mode_field_q;
	logic pd_q;
	logic to_q;
	logic startup_fast_q;
	logic xtal_mode_q;
	logic div4_q;
	logic low_to_t0_q;
	logic t0_src_q;
	logic from_halt_q;
	logic vec_q;
	logic wdclr_q;
	logic aw_hold_q;
	logic w_hold_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] bresp_q;
	logic [1:0] rresp_q;

	// ------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------
	// Address and data are latched independently; the write fires once
	// both are held and no response is pending.
	wire aw_take = s_axi_awvalid && !aw_hold_q;
	wire w_take = s_axi_wvalid && !w_hold_q;
	wire wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	wire wr_osc = wr_fire && awaddr_q == omc_pkg::OMC_OSC_CTRL_OFF
		&& wstrb_q[0];
	wire wr_cfg = wr_fire && awaddr_q == omc_pkg::OMC_CFG_OFF && wstrb_q[0];
	wire wr_ctrl = wr_fire && awaddr_q == omc_pkg::OMC_CTRL_OFF && wstrb_q[0];
	wire wr_known = awaddr_q == omc_pkg::OMC_OSC_CTRL_OFF
		|| awaddr_q == omc_pkg::OMC_CFG_OFF
		|| awaddr_q == omc_pkg::OMC_CTRL_OFF
		|| awaddr_q == omc_pkg::OMC_STAT_OFF;
	wire [1:0] wr_mode = wdata_q[omc_pkg::OMC_MODE_LO_BIT +: 2];

	assign s_axi_awready = !aw_hold_q;
	assign s_axi_wready = !w_hold_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Write channel holding registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
		end else begin
			if (aw_take) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
			end else if (wr_fire) begin
				aw_hold_q <= 1'b0;
			end
			if (w_take) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_hold_q <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_known ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------------
	wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'h0};
	wire rd_fire = s_axi_arvalid && !rvalid_q;
	wire [31:0] rd_osc = {28'h0, op_mode_field_q, hosc_stop_q, sel_high_q};
	wire [31:0] rd_cfg = {27'h0, t0_src_q, low_to_t0_q, div4_q,
		xtal_mode_q, startup_fast_q};
	wire [31:0] rd_stat = {24'h0, 3'h0, to_q, pd_q, 3'h0} |
		{24'h0, 5'h0, state_q};
	wire rd_known = rd_addr == omc_pkg::OMC_OSC_CTRL_OFF
		|| rd_addr == omc_pkg::OMC_CFG_OFF
		|| rd_addr == omc_pkg::OMC_CTRL_OFF
		|| rd_addr == omc_pkg::OMC_STAT_OFF;
	wire [31:0] rd_mux = rd_addr == omc_pkg::OMC_OSC_CTRL_OFF ? rd_osc :
		rd_addr == omc_pkg::OMC_CFG_OFF ? rd_cfg :
		rd_addr == omc_pkg::OMC_STAT_OFF ? rd_stat : 32'h0000_0000;

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Read data register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_known ? 2'h0 : 2'h2;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Mode sequencing
	// ------------------------------------------------------------------
	wire running = state_q == omc_pkg::OMC_ST_NORMAL
		|| state_q == omc_pkg::OMC_ST_SLOW;
	wire halt_req = running && (sleep_exec
		|| (wr_osc && wr_mode == omc_pkg::OMC_OP_MODE_FIELD_HALT));
	wire stby_req = running && !halt_req && wr_osc
		&& wr_mode == omc_pkg::OMC_OP_MODE_FIELD_STANDBY;
	wire wake_halt = watchdog_timeout || port_change
		|| ext_irq_zero || ext_irq_one;
	wire wake_stby = wake_halt || timer_expire
		|| lvd_irq || cmp_irq;
	wire halt_wake = state_q == omc_pkg::OMC_ST_HALT && wake_halt;
	wire stby_wake = state_q == omc_pkg::OMC_ST_STANDBY && wake_stby;
	wire [9:0] wake_count = xtal_mode_q ? omc_pkg::OMC_WAKE_XTAL_CYC
		: omc_pkg::OMC_WAKE_RC_CYC;
	wire wake_done;
	wire resume = stby_wake || wake_done;
	omc_pkg::omc_state_t run_mode;
	assign run_mode = sel_high_q ? omc_pkg::OMC_ST_NORMAL
		: omc_pkg::OMC_ST_SLOW;

	omc_wake_timer #(
		.WIDTH(10)
	) u_wake_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(halt_wake),
		.count(wake_count),
		.busy(),
		.done(wake_done)
	);

	// Next mode
	always_comb begin
		state_d = state_q;
		case (state_q)
			omc_pkg::OMC_ST_BOOT: begin
				state_d = startup_fast_q ? omc_pkg::OMC_ST_NORMAL
					: omc_pkg::OMC_ST_SLOW;
			end
			omc_pkg::OMC_ST_NORMAL, omc_pkg::OMC_ST_SLOW: begin
				if (halt_req) begin
					state_d = omc_pkg::OMC_ST_HALT;
				end else if (stby_req) begin
					state_d = omc_pkg::OMC_ST_STANDBY;
				end else if (wr_osc) begin
					state_d = wdata_q[omc_pkg::OMC_SEL_HIGH_BIT]
						? omc_pkg::OMC_ST_NORMAL
						: omc_pkg::OMC_ST_SLOW;
				end
			end
			omc_pkg::OMC_ST_STANDBY: begin
				if (stby_wake) begin
					state_d = run_mode;
				end
			end
			omc_pkg::OMC_ST_HALT: begin
				if (halt_wake) begin
					state_d = omc_pkg::OMC_ST_WAKE_WAIT;
				end
			end
			omc_pkg::OMC_ST_WAKE_WAIT: begin
				if (wake_done) begin
					state_d = run_mode;
				end
			end
			default: begin
				state_d = omc_pkg::OMC_ST_BOOT;
			end
		endcase
	end

	// Mode state and oscillator control register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= omc_pkg::OMC_ST_BOOT;
			sel_high_q <= omc_pkg::OMC_OSC_CTRL_RST[0];
			hosc_stop_q <= omc_pkg::OMC_OSC_CTRL_RST[1];
			op_mode_field_q <= omc_pkg::OMC_OSC_CTRL_RST[3:2];
		end else begin
			state_q <= state_d;
			if (state_q == omc_pkg::OMC_ST_BOOT) begin
				sel_high_q <= startup_fast_q;
			end else if (wr_osc) begin
				sel_high_q <= wdata_q[omc_pkg::OMC_SEL_HIGH_BIT];
				hosc_stop_q <= wdata_q[omc_pkg::OMC_HOSC_STOP_BIT];
			end
			if (resume) begin
				op_mode_field_q <= omc_pkg::OMC_OP_MODE_FIELD_RUN;
			end else if (halt_req) begin
				op_mode_field_q <= omc_pkg::OMC_OP_MODE_FIELD_HALT;
			end else if (stby_req) begin
				op_mode_field_q <= omc_pkg::OMC_OP_MODE_FIELD_STANDBY;
			end
		end
	end

	// Status flags, configuration and wake vector control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pd_q <= 1'b1;
			to_q <= 1'b1;
			startup_fast_q <= 1'b1;
			xtal_mode_q <= 1'b0;
			div4_q <= 1'b0;
			low_to_t0_q <= 1'b0;
			t0_src_q <= 1'b0;
			from_halt_q <= 1'b0;
			vec_q <= 1'b0;
			wdclr_q <= 1'b0;
		end else begin
			if (halt_req) begin
				pd_q <= 1'b0;
				to_q <= 1'b1;
			end else if (wr_ctrl && wdata_q[0]) begin
				pd_q <= 1'b1;
			end
			if (wr_cfg) begin
				startup_fast_q <= wdata_q[0];
				xtal_mode_q <= wdata_q[1];
				div4_q <= wdata_q[2];
				low_to_t0_q <= wdata_q[3];
				t0_src_q <= wdata_q[4];
			end
			if (halt_req || stby_req) begin
				from_halt_q <= irq_global_enable;
			end
			vec_q <= resume && from_halt_q;
			wdclr_q <= halt_req;
		end
	end

	// ------------------------------------------------------------------
	// Gating outputs
	// ------------------------------------------------------------------
	wire in_halt = state_q == omc_pkg::OMC_ST_HALT
		|| state_q == omc_pkg::OMC_ST_WAKE_WAIT;
	wire in_stby = state_q == omc_pkg::OMC_ST_STANDBY;

	assign cpu_run = running;
	assign sys_clk_is_high = sel_high_q;
	assign high_osc_enable = !hosc_stop_q && !in_halt;
	assign low_osc_enable = !in_halt;
	assign timer_clk_enable = in_halt ? '0 : timer_run_enable;
	assign timer0_from_low_osc = state_q == omc_pkg::OMC_ST_NORMAL
		&& low_to_t0_q && t0_src_q;
	assign periph_clk_enable = running ? periph_enable : '0;
	assign watchdog_run = watchdog_option && watchdog_run_enable;
	assign watchdog_clear = wdclr_q;
	assign inst_clk_div4 = div4_q;
	assign wake_vector_take = vec_q;
	assign wake_vector_addr = IRQ_VECTOR;
endmodule : omc_top
`default_nettype wire

// [omc_top_sva.sv]
// Checker for the operating mode controller, bound to omc_top.
// Assumes one clock aclk and a synchronous active-low aresetn.
`timescale 1ns/1ps
`default_nettype none
module omc_top_sva #(
	parameter int NUM_TIMERS = 6,
	parameter int NUM_PERIPH = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cpu_run,
	input wire logic sys_clk_is_high,
	input wire logic high_osc_enable,
	input wire logic low_osc_enable,
	input wire logic [NUM_TIMERS-1:0] timer_run_enable,
	input wire logic [NUM_TIMERS-1:0] timer_clk_enable,
	input wire logic [NUM_PERIPH-1:0] periph_enable,
	input wire logic [NUM_PERIPH-1:0] periph_clk_enable,
	input wire logic watchdog_option,
	input wire logic watchdog_run_enable,
	input wire logic watchdog_run,
	input wire logic watchdog_clear,
	input wire logic wake_vector_take,
	input wire logic [10:0] wake_vector_addr,
	input wire logic timer_expire,
	input wire logic watchdog_timeout,
	input wire logic port_change,
	input wire logic ext_irq_zero,
	input wire logic ext_irq_one,
	input wire logic lvd_irq,
	input wire logic cmp_irq
);
	// --------------------
	// Mode tracking
	// --------------------
	logic live_q;
	logic run_q;
	logic sb_q;
	wire logic halted = !low_osc_enable;
	wire logic standby = sb_q && !cpu_run && low_osc_enable;
	wire logic halt_wake = watchdog_timeout || port_change ||
		ext_irq_zero || ext_irq_one;

	// Skips the boot cycle; remembers a drop from running into standby
	always_ff @(posedge aclk) begin
		live_q <= aresetn;
		run_q <= cpu_run;
		sb_q <= !cpu_run && low_osc_enable && (run_q || sb_q);
	end

	// --------------------
	// Assertions
	// --------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn || !live_q);

	a_halt_all_off: assert property (
		halted |-> !cpu_run && !high_osc_enable && timer_clk_enable == '0 &&
		periph_clk_enable == '0) else $error("halt left a clock running");
	a_run_gating: assert property (
		cpu_run |-> low_osc_enable && periph_clk_enable == periph_enable)
		else $error("running mode gating wrong");
	a_normal_hosc: assert property (
		cpu_run && sys_clk_is_high |-> high_osc_enable)
		else $error("normal mode without high oscillator");
	a_standby_gate: assert property (
		standby |-> timer_clk_enable == timer_run_enable &&
		periph_clk_enable == '0) else $error("standby gating wrong");
	a_standby_wake: assert property (
		standby && timer_expire |-> ##[1:2] cpu_run)
		else $error("standby did not wake at once");
	a_wdt_gate: assert property (
		watchdog_run == (watchdog_option && watchdog_run_enable))
		else $error("watchdog run gating wrong");
	a_clear_pulse: assert property (
		watchdog_clear |-> halted ##1 !watchdog_clear)
		else $error("watchdog clear pulse wrong");
	a_halt_ignore: assert property (
		halted && (timer_expire || lvd_irq || cmp_irq) && !halt_wake
		|=> !cpu_run) else $error("halt woke on a wrong source");
	a_halt_wait: assert property (
		halted && ext_irq_zero |=> (!cpu_run)[*8] ##[7:600] cpu_run)
		else $error("halt wake delay wrong");
	a_vector: assert property (
		wake_vector_take |-> ##[0:1] cpu_run && wake_vector_addr == 11'h008)
		else $error("wake vector wrong");

	c_standby_wake: cover property (standby && timer_expire);
	c_halt_entry: cover property (watchdog_clear);
	c_vector: cover property (wake_vector_take);
endmodule : omc_top_sva

bind omc_top omc_top_sva #(.NUM_TIMERS(NUM_TIMERS),
	.NUM_PERIPH(NUM_PERIPH)) u_sva (.*);
`default_nettype wire

// [tb_omc_top.sv]
// Bench for omc_top: AXI4-Lite master tasks, wake pulses and checks.
// Assumes omc_pkg and omc_top are compiled first; one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_omc_top;
	logic aclk, aresetn, sleep_exec, irq_global_enable, watchdog_option;
	logic watchdog_run_enable, timer_expire, watchdog_timeout, port_change;
	logic ext_irq_zero, ext_irq_one, lvd_irq, cmp_irq, cpu_run, sel;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, sys_clk_is_high, high_osc_enable;
	logic low_osc_enable, timer0_from_low_osc, watchdog_run, watchdog_clear;
	logic inst_clk_div4, wake_vector_take;
	logic [5:0] timer_run_enable, timer_clk_enable;
	logic [3:0] periph_enable, periph_clk_enable, s_axi_wstrb;
	logic [7:0] s_axi_awaddr, s_axi_araddr, lf;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [10:0] wake_vector_addr;
	logic [6:0] ev;
	int num_errors, cmp_count, vt, wc, n;

	// Wake event bus: bit order matches the source list below
	assign {cmp_irq, lvd_irq, ext_irq_one, ext_irq_zero, port_change,
		watchdog_timeout, timer_expire} = ev;
	omc_top dut (.*);

	// Clock, watchdog and pulse counters
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	initial begin
		#200us;
		num_errors++;
		report_and_stop();
	end
	always @(negedge aclk) begin
		vt += (wake_vector_take === 1'b1);
		wc += (watchdog_clear === 1'b1);
	end

	// --------------------
	// Tasks
	// --------------------
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : nx
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, ka, kw;
		ta = 0;
		tw = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge aclk);
			ka = s_axi_awvalid && s_axi_awready;
			kw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (ka) s_axi_awvalid <= 1'b0;
			if (kw) s_axi_wvalid <= 1'b0;
			ta = ta || ka;
			tw = tw || kw;
		end
		do begin
			@(negedge aclk);
			rs = s_axi_bresp;
		end while (s_axi_bvalid !== 1'b1);
		@(posedge aclk);
		s_axi_bready <= 1'b0;
		@(negedge aclk);
	endtask : wr
	task automatic rdreg(input logic [7:0] a);
		logic k;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			k = s_axi_arready;
			@(posedge aclk);
		end while (k !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			rd = s_axi_rdata;
			rs = s_axi_rresp;
		end while (s_axi_rvalid !== 1'b1);
		@(posedge aclk);
		s_axi_rready <= 1'b0;
		@(negedge aclk);
	endtask : rdreg
	// One-cycle pulse on wake source i, then count cycles until running
	task automatic wake(input int i);
		@(posedge aclk);
		ev <= 7'h01 << i;
		@(posedge aclk);
		ev <= '0;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (cpu_run !== 1'b1 && n < 2000);
		repeat (2) @(negedge aclk);
		check(sys_clk_is_high, sel);
		check(vt, irq_global_enable);
		rdreg(8'h00);
		check(rd[3:2], 2'h0);
	endtask : wake
	// Random clock choice, enables and interrupt state before a sleep
	task automatic pick;
		lf = nx(lf);
		sel = lf[0];
		irq_global_enable <= lf[1];
		timer_run_enable <= lf[7:2];
		periph_enable <= lf[5:2];
		watchdog_option <= lf[6];
		watchdog_run_enable <= lf[7];
		wr(8'h00, {31'h0, sel});
		check(watchdog_run, watchdog_option & watchdog_run_enable);
		vt = 0;
		wc = 0;
	endtask : pick
	task automatic report_and_stop;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	// --------------------
	// Main sequence
	// --------------------
	initial begin
		aresetn = 1'b0;
		ev = '0;
		{sleep_exec, irq_global_enable, watchdog_option, sel} = '0;
		{watchdog_run_enable, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{timer_run_enable, periph_enable} = '0;
		s_axi_wstrb = 4'hf;
		lf = 8'h59;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rdreg(8'h00);
		check(rd[3:0], omc_pkg::OMC_OSC_CTRL_RST);
		check(cpu_run & sys_clk_is_high, 1);
		rdreg(8'h0c);
		check(rd[4:3], 2'h3);
		rdreg(8'h10);
		check(rs, 2'h2);
		wr(8'h14, 0);
		check(rs, 2'h2);
		wr(8'h00, 0);
		check({cpu_run, sys_clk_is_high, high_osc_enable}, 3'h5);
		wr(8'h00, 2);
		check(high_osc_enable, 0);
		wr(8'h00, 1);
		check({sys_clk_is_high, high_osc_enable}, 2'h3);
		wr(8'h04, 32'h19);
		check({timer0_from_low_osc, inst_clk_div4}, 2'h2);
		wr(8'h04, 5);
		check({timer0_from_low_osc, inst_clk_div4}, 2'h1);
		for (int i = 0; i < 7; i++) begin
			pick();
			wr(8'h00, {28'h0, 2'h2, 1'b0, sel});
			check({cpu_run, low_osc_enable}, 2'h1);
			check(timer_clk_enable, timer_run_enable);
			wake(i);
			check(n <= 2, 1);
		end
		for (int i = 1; i < 5; i++) begin
			pick();
			wr(8'h08, 1);
			if (i[0]) begin
				wr(8'h00, {28'h0, 2'h1, 1'b0, sel});
			end else begin
				sleep_exec <= 1'b1;
				@(posedge aclk);
				sleep_exec <= 1'b0;
				repeat (3) @(negedge aclk);
			end
			check({cpu_run, low_osc_enable, high_osc_enable}, 0);
			check(wc, 1);
			rdreg(8'h0c);
			check(rd[4:3], 2'h2);
			for (int j = 0; j < 7; j += 5 - j / 5 * 4) begin
				@(posedge aclk);
				ev <= 7'h01 << j;
				@(posedge aclk);
				ev <= '0;
			end
			check(cpu_run, 0);
			wake(i);
			check(n >= 16 && n <= 20, 1);
		end
		wr(8'h04, 3);
		pick();
		wr(8'h00, {28'h0, 2'h1, 1'b0, sel});
		wake(2);
		check(n >= 512 && n <= 516, 1);
		report_and_stop();
	end
endmodule : tb_omc_top
`default_nettype wire
